// [rtl/hdb_pkg.sv]
// Package for the host data buffer port: register selects, status layout, vectors.
// Assumes both ends and the checker import it whole.
package hdb_pkg;
    localparam int DATA_W = 8;
    // Register select levels
    localparam logic SEL_DATA = 1'h0;
    localparam logic SEL_CMD = 1'h1;
    // Status bit positions
    localparam int ST_OBF = 0;
    localparam int ST_IBF = 1;
    localparam int ST_USER = 2;
    localparam int ST_CD = 3;
    localparam int ST_UPPER = 4;
    // Input-full service vector
    localparam logic [11:0] IBF_VECTOR = 12'h003;
    // Host-side controller register offsets
    localparam logic [2:0] HC_CTRL = 3'h0;
    localparam logic [2:0] HC_WDATA = 3'h1;
    localparam logic [2:0] HC_RDATA = 3'h2;
    localparam logic [2:0] HC_STAT = 3'h3;
    localparam logic [2:0] HC_IRQST = 3'h4;
    localparam logic [2:0] HC_IRQMSK = 3'h5;
    // Control bits of the host controller
    localparam int CT_WRITE = 0;
    localparam int CT_CMD = 1;
    localparam int CT_READ = 2;
    // Interrupt status bits of the host controller
    localparam int IQ_WDONE = 0;
    localparam int IQ_RDONE = 1;
    localparam logic [7:0] ZERO8 = 8'h00;
endpackage

// [rtl/hdb_if.sv]
// Carrier joining the master and the peripheral data buffer port.
// The carrier resolves the three-state data bus from the enables.
`timescale 1ns/1ps
interface hdb_if;
    logic cs_n; // Chip select, low active
    logic rsel; // Register select
    logic rd_n; // Read strobe, low active
    logic wr_n; // Write strobe, low active
    logic [7:0] d_mst_o; // Master drive value
    logic d_mst_oe; // Master drives bus
    logic [7:0] d_dev_o; // Device drive value
    logic d_dev_oe; // Device drives bus
    logic [7:0] d_bus; // Resolved bus level
    always_comb begin
        if (d_dev_oe)
            d_bus = d_dev_o;
        else if (d_mst_oe)
            d_bus = d_mst_o;
        else
            d_bus = 8'hff;
    end
    modport master (output cs_n, rsel, rd_n, wr_n, d_mst_o, d_mst_oe, input d_bus);
    modport device (input cs_n, rsel, rd_n, wr_n, d_bus, output d_dev_o, d_dev_oe);
endinterface

// [rtl/hdb_sync.sv]
// Two-stage synchroniser bank for pin inputs.
// Assumes one clock, synchronous reset, clock enable.
`timescale 1ns/1ps
module hdb_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic [W-1:0] d, // Asynchronous input
    output logic [W-1:0] q // Synchronised output
);
    logic [W-1:0] meta_q;
    // First stage read only by the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= INIT;
            q <= INIT;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// [rtl/hdb_device.sv]
// Peripheral end: input/output buffers, status, input-full interrupt.
// Assumes the master keeps the status handshake; pins are asynchronous.
`timescale 1ns/1ps

// How it works
// R1: Decode chip select, select, strobes
// R2: Drive data lines only on selected read
// R3: Data read shows output buffer
// R4: Output buffer read clears output-full
// R5: Status read, buffers untouched
// R6: Write captures byte, sets input-full
// R7: Data write clears command flag, requests interrupt
// R8: Command write latches select into flag
// R9: Command write sets input-full, requests interrupt
// R10: Enabled pending request vectors to three
// R11: Request cleared on service entry or reset
// R12: Buffer-to-accumulator copies and clears input-full
// R13: Accumulator-to-buffer loads and sets output-full
// R14: Master reads status before transfer
// R15: Master writes only when input-full clear
// R16: Master reads only when output-full set
// R17: Controller handles byte by command flag
// R18: Controller loads output when output-full clear
// R19: Status bits: OUTPUT_FULL_FLAG, INPUT_FULL_FLAG, user, command
module hdb_device
    import hdb_pkg::*;
(
    input wire logic REF_CLK, // 10 MHz clock
    input wire logic RSTN, // Synchronous reset, low
    input wire logic CE, // Clock enable
    hdb_if.device BUS, // Master-facing port
    input wire logic IBF_IRQ_EN, // Input-full interrupt enable
    input wire logic SVC_ENTER, // Controller enters service routine
    input wire logic BUF_TO_ACC, // Buffer-to-accumulator operation
    input wire logic ACC_TO_BUF, // Accumulator-to-buffer operation
    input wire logic [7:0] ACC_IN, // Accumulator value
    input wire logic USER_FLAG, // User status flag
    input wire logic [3:0] USER_UPPER, // User upper status bits
    output logic [7:0] ACC_OUT, // Byte taken from input buffer
    output logic IS_COMMAND, // Taken byte was a command
    output logic IBF_PEND, // Input-full request pending
    output logic VECTOR_REQ, // Jump request to vector
    output logic [11:0] VECTOR_ADDR, // Vector address
    output logic INPUT_FULL, // Input-full flag
    output logic OUTPUT_FULL // Output-full flag
);
    logic cs_n_s, rsel_s, rd_n_s, wr_n_s;
    logic [7:0] d_s;
    logic rd_sel_q, wr_sel_q, rd_rsel_q, wr_rsel_q;
    logic [7:0] in_buf_q, out_buf_q, acc_q;
    logic ibf_q, obf_q, cd_q, pend_q, cmd_q;
    logic rd_sel, wr_sel, rd_end, wr_end;
    logic [7:0] status_q;

    ////////////////////////////////////////////////////////////////////////
    // Limits of this end
    // Every pin passes two flops, so strobes need three low cycles
    // Shorter strobes may be missed altogether
    // Transfers act on strobe release, after the bus has settled
    // A master write while input-full is set overwrites the unread byte
    // The read enable uses the raw pins so the bus floats at once

    // Selected strobe: chip select and strobe both low
    function automatic logic strobe_on(input logic cs_n, input logic strobe_n);
        return !cs_n && !strobe_n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; strobes idle high
    // Data lines are synchronised too; they are used only at strobe release
    hdb_sync #(.W(4), .INIT(4'hf)) u_ctl (
        .clk(REF_CLK), .rst_n(RSTN), .ce(CE),
        .d({BUS.cs_n, BUS.rsel, BUS.rd_n, BUS.wr_n}),
        .q({cs_n_s, rsel_s, rd_n_s, wr_n_s})
    );
    hdb_sync #(.W(8), .INIT(8'h00)) u_dat (
        .clk(REF_CLK), .rst_n(RSTN), .ce(CE), .d(BUS.d_bus), .q(d_s)
    );

    // Selected-strobe history; the select level is kept from inside the strobe,
    // since the master may move select and chip select as the strobe rises
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            rd_sel_q <= 1'h0;
            wr_sel_q <= 1'h0;
            rd_rsel_q <= SEL_DATA;
            wr_rsel_q <= SEL_DATA;
        end else if (CE) begin
            rd_sel_q <= rd_sel;
            wr_sel_q <= wr_sel;
            if (rd_sel)
                rd_rsel_q <= rsel_s;
            if (wr_sel)
                wr_rsel_q <= rsel_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer decode; act on strobe release so the data bus has settled
    assign rd_sel = strobe_on(cs_n_s, rd_n_s); // [R1]
    assign wr_sel = strobe_on(cs_n_s, wr_n_s); // [R1]
    // A transfer ends when its strobe rises; chip select may rise with it
    assign rd_end = rd_sel_q && rd_n_s; // [R1]
    assign wr_end = wr_sel_q && wr_n_s; // [R1]

    // Status held in flops so the read mux picks between flops only
    always_ff @(posedge REF_CLK) begin
        if (!RSTN)
            status_q <= ZERO8;
        else if (CE)
            status_q <= {USER_UPPER, cd_q, USER_FLAG, ibf_q, obf_q}; // [R19]
    end

    // Bus drive: combinational enable from pins, so the read is served at once
    // A synchronised enable would float the bus late and clash with a write
    always_comb begin
        BUS.d_dev_oe = !BUS.cs_n && !BUS.rd_n && BUS.wr_n; // [R2]
        if (BUS.rsel == SEL_CMD)
            BUS.d_dev_o = status_q; // [R5]
        else
            BUS.d_dev_o = out_buf_q; // [R3]
    end

    ////////////////////////////////////////////////////////////////////////
    // Input buffer and command flag
    // The select level comes from inside the strobe, not from its release
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            in_buf_q <= ZERO8;
            cd_q <= SEL_DATA;
        end else if (CE && wr_end) begin
            in_buf_q <= d_s; // [R6]
            cd_q <= wr_rsel_q; // [R7] [R8]
        end
    end

    // Input-full: a host write wins over a same-cycle internal take
    // Losing the set would hide a byte the master believes delivered
    always_ff @(posedge REF_CLK) begin
        if (!RSTN)
            ibf_q <= 1'h0;
        else if (CE) begin
            if (wr_end)
                ibf_q <= 1'h1; // [R6] [R9]
            else if (BUF_TO_ACC)
                ibf_q <= 1'h0; // [R12] [R17]
        end
    end

    // Interrupt request: set wins over service-entry clear
    // Reset clears it as well, through the first branch
    always_ff @(posedge REF_CLK) begin
        if (!RSTN)
            pend_q <= 1'h0; // [R11]
        else if (CE) begin
            if (wr_end)
                pend_q <= 1'h1; // [R7] [R9]
            else if (SVC_ENTER)
                pend_q <= 1'h0; // [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator side: take input byte with its command flag
    // The flag travels with the byte, so a later write cannot relabel it
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            acc_q <= ZERO8;
            cmd_q <= SEL_DATA;
        end else if (CE && BUF_TO_ACC) begin
            acc_q <= in_buf_q; // [R12]
            cmd_q <= cd_q; // [R17]
        end
    end

    // Output buffer load; the controller checks output-full first
    // No guard here: loading over an unread byte replaces it
    always_ff @(posedge REF_CLK) begin
        if (!RSTN)
            out_buf_q <= ZERO8;
        else if (CE && ACC_TO_BUF)
            out_buf_q <= ACC_IN; // [R13] [R18]
    end

    // Output-full: internal load wins over a same-cycle master read
    // Losing the set would leave a fresh byte unannounced
    always_ff @(posedge REF_CLK) begin
        if (!RSTN)
            obf_q <= 1'h0;
        else if (CE) begin
            if (ACC_TO_BUF)
                obf_q <= 1'h1; // [R13]
            else if (rd_end && rd_rsel_q == SEL_DATA)
                obf_q <= 1'h0; // [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Controller-facing outputs
    // Vector request is a plain gate; the enable may change at any time
    assign ACC_OUT = acc_q;
    assign IS_COMMAND = cmd_q;
    assign IBF_PEND = pend_q;
    assign VECTOR_REQ = pend_q && IBF_IRQ_EN; // [R10]
    assign VECTOR_ADDR = IBF_VECTOR; // [R10]
    assign INPUT_FULL = ibf_q;
    assign OUTPUT_FULL = obf_q;
endmodule

// [rtl/hdb_master.sv]
// Master end: polls status, writes data or commands, reads output bytes.
// Assumes a software port on the same clock; bus pins are asynchronous.
`timescale 1ns/1ps
module hdb_master
    import hdb_pkg::*;
#(
    parameter int STROBE_CYC = 3 // Write strobe low time in cycles; read strobes last two more
) (
    input wire logic REF_CLK, // 10 MHz clock
    input wire logic RSTN, // Synchronous reset, low
    input wire logic CE, // Clock enable
    hdb_if.master BUS, // Peripheral-facing port
    input wire logic [2:0] ADDR, // Register address
    input wire logic [7:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [7:0] RDATA, // Read data, cycle after RD
    output logic IRQ // Level interrupt
);
    typedef enum logic [4:0] {
        S_IDLE = 5'h01, S_POLL = 5'h02, S_CHK = 5'h04, S_XFER = 5'h08, S_GAP = 5'h10
    } hdb_st_t;
    hdb_st_t st_q;
    logic [7:0] bus_s, wbyte_q, rbyte_q, stat_q, rdata_q;
    logic wpend_q, cmd_q, rpend_q, doing_wr_q;
    logic [1:0] irq_st_q, irq_msk_q;
    logic [7:0] cnt_q;
    logic done_w, done_r;

    hdb_sync #(.W(8), .INIT(8'h00)) u_dat (
        .clk(REF_CLK), .rst_n(RSTN), .ce(CE), .d(BUS.d_bus), .q(bus_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: status read always precedes a transfer [R14]
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            st_q <= S_IDLE;
            cnt_q <= ZERO8;
            stat_q <= ZERO8;
            rbyte_q <= ZERO8;
            doing_wr_q <= 1'h0;
        end else if (CE) begin
            case (st_q)
                S_IDLE: begin
                    cnt_q <= ZERO8;
                    if (wpend_q || rpend_q)
                        st_q <= S_POLL;
                end
                S_POLL: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(STROBE_CYC + 2)) begin
                        stat_q <= bus_s; // Sample after sync latency
                        st_q <= S_CHK;
                    end
                end
                S_CHK: begin
                    cnt_q <= ZERO8;
                    if (wpend_q && !stat_q[ST_IBF]) begin
                        doing_wr_q <= 1'h1; // [R15]
                        st_q <= S_XFER;
                    end else if (rpend_q && stat_q[ST_OBF]) begin
                        doing_wr_q <= 1'h0; // [R16]
                        st_q <= S_XFER;
                    end else
                        st_q <= S_GAP;
                end
                S_XFER: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(STROBE_CYC + 2)) begin
                        if (!doing_wr_q)
                            rbyte_q <= bus_s;
                        cnt_q <= ZERO8; // Gap counts from zero
                        st_q <= S_GAP;
                    end
                end
                S_GAP: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(STROBE_CYC))
                        st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    assign done_w = CE && st_q == S_XFER && cnt_q == 8'(STROBE_CYC + 2) && doing_wr_q;
    assign done_r = CE && st_q == S_XFER && cnt_q == 8'(STROBE_CYC + 2) && !doing_wr_q;

    // Bus pins from flops; strobe held through sampling
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            BUS.cs_n <= 1'h1;
            BUS.rsel <= SEL_DATA;
            BUS.rd_n <= 1'h1;
            BUS.wr_n <= 1'h1;
            BUS.d_mst_o <= ZERO8;
            BUS.d_mst_oe <= 1'h0;
        end else if (CE) begin
            BUS.cs_n <= !(st_q == S_POLL || st_q == S_XFER) || cnt_q > 8'(STROBE_CYC + 1);
            BUS.rsel <= (st_q == S_POLL) ? SEL_CMD : (doing_wr_q ? cmd_q : SEL_DATA); // [R1]
            BUS.rd_n <= !((st_q == S_POLL || (st_q == S_XFER && !doing_wr_q))
                          && cnt_q <= 8'(STROBE_CYC + 1));
            BUS.wr_n <= !(st_q == S_XFER && doing_wr_q && cnt_q <= 8'(STROBE_CYC - 1));
            BUS.d_mst_o <= wbyte_q;
            BUS.d_mst_oe <= st_q == S_XFER && doing_wr_q && cnt_q <= 8'(STROBE_CYC + 1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software register writes and job flags; completion wins over nothing new
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            wpend_q <= 1'h0;
            rpend_q <= 1'h0;
            cmd_q <= SEL_DATA;
            wbyte_q <= ZERO8;
            irq_msk_q <= 2'h0;
        end else if (CE) begin
            if (done_w)
                wpend_q <= 1'h0;
            if (done_r)
                rpend_q <= 1'h0;
            if (WR) begin
                if (ADDR == HC_WDATA)
                    wbyte_q <= WDATA;
                else if (ADDR == HC_IRQMSK)
                    irq_msk_q <= WDATA[1:0];
                else if (ADDR == HC_CTRL) begin
                    if (WDATA[CT_WRITE] && !wpend_q) begin
                        wpend_q <= 1'h1;
                        cmd_q <= WDATA[CT_CMD];
                    end
                    if (WDATA[CT_READ])
                        rpend_q <= 1'h1;
                end
            end
        end
    end

    // Sticky events; set wins over read-clear
    always_ff @(posedge REF_CLK) begin
        if (!RSTN)
            irq_st_q <= 2'h0;
        else if (CE)
            irq_st_q <= (RD && ADDR == HC_IRQST ? 2'h0 : irq_st_q) | {done_r, done_w};
    end

    // Read port, data in the cycle after RD
    always_ff @(posedge REF_CLK) begin
        if (!RSTN)
            rdata_q <= ZERO8;
        else if (CE) begin
            if (!RD)
                rdata_q <= ZERO8;
            else if (ADDR == HC_CTRL)
                rdata_q <= {5'h00, rpend_q, cmd_q, wpend_q};
            else if (ADDR == HC_WDATA)
                rdata_q <= wbyte_q;
            else if (ADDR == HC_RDATA)
                rdata_q <= rbyte_q;
            else if (ADDR == HC_STAT)
                rdata_q <= stat_q;
            else if (ADDR == HC_IRQST)
                rdata_q <= {6'h00, irq_st_q};
            else if (ADDR == HC_IRQMSK)
                rdata_q <= {6'h00, irq_msk_q};
            else
                rdata_q <= ZERO8;
        end
    end
    assign RDATA = rdata_q;
    assign IRQ = |(irq_st_q & irq_msk_q);
endmodule

// [sim/hdb_props.sv]
// Checker for the bus that joins the master end and the peripheral end.
// Assumes the bench instantiates it beside the carrier, with one clock.
`timescale 1ns/1ps
module hdb_props
    import hdb_pkg::*;
(
    input wire logic REF_CLK, // Clock
    input wire logic RSTN, // Synchronous reset, low
    input wire logic cs_n, // Chip select, low
    input wire logic rsel, // Register select
    input wire logic rd_n, // Read strobe, low
    input wire logic wr_n, // Write strobe, low
    input wire logic [7:0] d_mst_o, // Master drive value
    input wire logic d_mst_oe, // Master drives bus
    input wire logic [7:0] d_dev_o, // Device drive value
    input wire logic d_dev_oe, // Device drives bus
    input wire logic [7:0] d_bus // Resolved bus
);
    ////////////////////////////////////////////////////////////////////////////
    // Select level of the last write; taken during the strobe, not at release
    logic seen_q;
    logic sel_q;
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            seen_q <= 1'b0;
            sel_q <= 1'b0;
        end else if (!cs_n && !wr_n) begin
            seen_q <= 1'b1;
            sel_q <= rsel;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    oe_only_read_a: assert property (d_dev_oe |-> !cs_n && !rd_n && wr_n)
        else $error("device drives bus outside a selected read");
    read_drives_a: assert property (!cs_n && !rd_n && wr_n |-> d_dev_oe)
        else $error("device silent during a selected read");
    cs_ignore_a: assert property (cs_n |-> !d_dev_oe)
        else $error("device answers while deselected");
    strobe_excl_a: assert property (!(!rd_n && !wr_n))
        else $error("both strobes low");
    rd_width_a: assert property ($fell(rd_n) |-> (!rd_n && !cs_n)[*3])
        else $error("read strobe too short");
    wr_width_a: assert property ($fell(wr_n) |-> (!wr_n && !cs_n)[*3])
        else $error("write strobe too short");
    wr_data_a: assert property (!wr_n && !$past(wr_n) |-> $stable(d_mst_o) && d_mst_oe)
        else $error("write data not held");
    cd_flag_a: assert property (d_dev_oe && rsel && seen_q && !$past(rd_n) && !$past(rd_n, 2)
        |-> d_dev_o[ST_CD] == sel_q)
        else $error("command flag differs from last select");
    bus_contend_a: assert property (!(d_dev_oe && d_mst_oe))
        else $error("both ends drive the data bus");
    bus_resolve_a: assert property (d_dev_oe |-> d_bus == d_dev_o)
        else $error("bus does not show the device byte");
endmodule

// [sim/host_data_buffer_port_tb.sv]
// Bench: master end driven from its software port, peripheral end from its
// controller side. Assumes the carrier resolves the data bus.
`timescale 1ns/1ps
module host_data_buffer_port_tb;
    import hdb_pkg::*;
    logic ref_clk;
    logic rstn = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] ops = 3'h0; // {load out, take in, service}
    logic ibf_en = 1'b1;
    logic [7:0] acc_in = 8'h00;
    logic user_flag = 1'b0;
    logic [3:0] user_upper = 4'h0;
    logic [7:0] rdata, acc_out, rv;
    logic [11:0] vaddr;
    logic irq, is_cmd, pend, vreq, in_full, out_full;
    int n_fail = 0;
    int n_tests = 0;
    ////////////////////////////////////////////////////////////////////////////
    hdb_if i_hdb_if();
    hdb_master i_hdb_master (.REF_CLK(ref_clk), .RSTN(rstn), .CE(1'b1), .BUS(i_hdb_if),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq));
    hdb_device i_hdb_device (.REF_CLK(ref_clk), .RSTN(rstn), .CE(1'b1), .BUS(i_hdb_if),
        .IBF_IRQ_EN(ibf_en), .SVC_ENTER(ops[0]), .BUF_TO_ACC(ops[1]), .ACC_TO_BUF(ops[2]),
        .ACC_IN(acc_in), .USER_FLAG(user_flag), .USER_UPPER(user_upper), .ACC_OUT(acc_out),
        .IS_COMMAND(is_cmd), .IBF_PEND(pend), .VECTOR_REQ(vreq), .VECTOR_ADDR(vaddr),
        .INPUT_FULL(in_full), .OUTPUT_FULL(out_full));
    hdb_props i_hdb_props (.REF_CLK(ref_clk), .RSTN(rstn), .cs_n(i_hdb_if.cs_n),
        .rsel(i_hdb_if.rsel), .rd_n(i_hdb_if.rd_n), .wr_n(i_hdb_if.wr_n),
        .d_mst_o(i_hdb_if.d_mst_o), .d_mst_oe(i_hdb_if.d_mst_oe), .d_dev_o(i_hdb_if.d_dev_o),
        .d_dev_oe(i_hdb_if.d_dev_oe), .d_bus(i_hdb_if.d_bus));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Compares count every call and report at once
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t flag %b, expected %b", $time, got, exp);
        end
    endtask
    // Software port: one-cycle strobes, read data in the following cycle only
    task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic sw_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        sw_rd(a, d);
        chk8(d, exp);
    endtask
    // Controller operations are one-cycle pulses
    task automatic op(input logic [2:0] m);
        @(posedge ref_clk);
        ops <= m;
        @(posedge ref_clk);
        ops <= 3'h0;
        #1;
    endtask
    // Bounded wait: 0 input full, 1 output full, 2 master interrupt
    task automatic wait_for(input int sel, input logic v);
        for (int i = 0; i < 300; i++) begin
            @(posedge ref_clk);
            #1;
            if ((sel == 0 ? in_full : sel == 1 ? out_full : irq) === v) break;
        end
        chk1(sel == 0 ? in_full : sel == 1 ? out_full : irq, v);
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        test_done();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk1(in_full, 1'b0);
        chk1(out_full, 1'b0);
        chk1(pend, 1'b0);
        chk8(vaddr[7:0], 8'h03);
        chk8(vaddr[11:4], 8'h00);
        $display("test reset done");
        // Data write, service entry, take into accumulator
        sw_wr(HC_IRQMSK, 8'h03);
        sw_wr(HC_WDATA, 8'ha5);
        sw_wr(HC_CTRL, 8'h01);
        wait_for(0, 1'b1);
        chk1(pend, 1'b1);
        chk1(vreq, 1'b1);
        op(3'h1);
        chk1(pend, 1'b0);
        chk1(in_full, 1'b1);
        op(3'h2);
        chk8(acc_out, 8'ha5);
        chk1(is_cmd, 1'b0);
        chk1(in_full, 1'b0);
        wait_for(2, 1'b1);
        rd_chk(HC_IRQST, 8'h01);
        wait_for(2, 1'b0);
        $display("test data write done");
        // Command left unread while the master waits for output, irq masked
        @(posedge ref_clk);
        user_flag <= 1'b1;
        user_upper <= 4'ha;
        ibf_en <= 1'b0;
        sw_wr(HC_WDATA, 8'h3c);
        sw_wr(HC_CTRL, 8'h03);
        wait_for(0, 1'b1);
        chk1(pend, 1'b1);
        chk1(vreq, 1'b0);
        sw_wr(HC_IRQMSK, 8'h00);
        sw_wr(HC_CTRL, 8'h04);
        repeat (60) @(posedge ref_clk);
        sw_rd(HC_CTRL, rv);
        chk1(rv[CT_READ], 1'b1);
        rd_chk(HC_STAT, 8'hae);
        chk1(in_full, 1'b1);
        @(posedge ref_clk);
        acc_in <= 8'h5a;
        op(3'h4);
        chk1(out_full, 1'b1);
        wait_for(1, 1'b0);
        chk1(irq, 1'b0);
        sw_wr(HC_IRQMSK, 8'h02);
        wait_for(2, 1'b1);
        rd_chk(HC_RDATA, 8'h5a);
        rd_chk(HC_IRQST, 8'h03);
        // Unmapped offset, access only
        sw_rd(3'h6, rv);
        $display("test command and read done");
        // Data write held off while the command still fills the input buffer
        sw_wr(HC_WDATA, 8'h77);
        sw_wr(HC_CTRL, 8'h01);
        repeat (60) @(posedge ref_clk);
        sw_rd(HC_CTRL, rv);
        chk1(rv[CT_WRITE], 1'b1);
        op(3'h2);
        chk8(acc_out, 8'h3c);
        chk1(is_cmd, 1'b1);
        op(3'h1);
        chk1(pend, 1'b0);
        wait_for(0, 1'b1);
        chk1(pend, 1'b1);
        $display("test held write done");
        // Reset in mid-run drops the pending request
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk1(pend, 1'b0);
        chk1(in_full, 1'b0);
        $display("test second reset done");
        test_done();
    end
endmodule
